// ===== act_defs.svh
/*
  Constants for the channel trim register bank: register indices, field
  positions, reset values and datapath figures.
  Assumes it is included by its bare name by the package and the testbench.
*/
//
// Overview of operation
// R1: Setup register bits 15:6 hold a ten-bit signed phase delay in modulator clock cycles.
// R2: Setup bit 2 set bypasses the high-pass filter for this channel, clear follows the shared setting.
// R3: Setup bits 1:0 pick own pins, shorted inputs, positive test or negative test signal.
// R4: The upper offset register holds bits 23:8 of the signed offset trim in its whole field.
// R5: The lower offset register holds bits 7:0 of the offset trim in its bits 15:8.
// R6: The upper gain register holds bits 23:8 of the gain trim in its whole field.
// R7: The lower gain register holds bits 7:0 of the gain trim in its bits 15:8.
// R8: The gain trim is an unsigned factor from 0.0 to just under 2.0.
// R9: Reserved bits are read-only and read zero.
// R10: Each trim is upper word joined to lower byte and applied to the results.
`ifndef ACT_DEFS_SVH
`define ACT_DEFS_SVH

// ------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------------
`define ACT_IDX_W        8
`define ACT_IDX_SETUP    8'h0e
`define ACT_IDX_OFF_HI   8'h0f
`define ACT_IDX_OFF_LO   8'h10
`define ACT_IDX_GAIN_HI  8'h11
`define ACT_IDX_GAIN_LO  8'h12

// ------------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------------
`define ACT_PHASE_HI     15
`define ACT_PHASE_LO     6
`define ACT_BYP_BIT      2
`define ACT_SEL_HI       1
`define ACT_SEL_LO       0
`define ACT_LOWB_HI      15
`define ACT_LOWB_LO      8
`define ACT_RST_SETUP    16'h0000
`define ACT_RST_OFF_HI   16'h0000
`define ACT_RST_OFF_LO   8'h00
`define ACT_RST_GAIN_HI  16'h8000
`define ACT_RST_GAIN_LO  8'h00
`define ACT_HP_OFF       4'h0
`define ACT_GAIN_FRAC    23

`endif

// ===== act_pkg.sv
/*
  Types for the channel trim register bank.
  Assumes act_defs.svh is on the include path.
*/
package act_pkg;
  `include "act_defs.svh"

  typedef enum logic [1:0] {
    ACT_SEL_OWN_PINS,
    ACT_SEL_SHORTED,
    ACT_SEL_TEST_POS,
    ACT_SEL_TEST_NEG
  } act_sel_e;

  typedef struct packed {
    logic                valid;
    logic signed [23:0]  data;
  } act_sample_s;

  typedef struct packed {
    logic                   valid;
    logic                   write;
    logic [`ACT_IDX_W-1:0]  idx;
  } act_aphase_s;
endpackage : act_pkg

// ===== act_channel_trim.sv
/*
  One converter channel's setup, offset trim and gain trim registers as an
  AHB-Lite slave, plus the trim stage that applies them to the channel's
  conversion results.
  Assumes samples and the shared high-pass setting come from logic on hclk,
  and that the master issues single word transfers only.
*/
`timescale 1ns/10ps
module act_channel_trim (
  // Clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // Channel controls
  input  wire logic [3:0]           shared_highpass_setting,
  output logic      [9:0]           phase_delay_trim,
  output logic                      highpass_bypass,
  output act_pkg::act_sel_e         input_selector,
  output logic      [3:0]           highpass_setting,
  output logic      [23:0]          offset_trim,
  output logic      [23:0]          gain_trim,
  // Conversion results
  input  act_pkg::act_sample_s      sample_in,
  output act_pkg::act_sample_s      sample_out
);
  import act_pkg::*;

  // ----------------------------------------------------------------
  // Register storage (writable bits only)
  // ----------------------------------------------------------------
  logic [9:0]          phase_q,   phase_d;
  logic                byp_q,     byp_d;
  logic [1:0]          sel_q,     sel_d;
  logic [15:0]         off_hi_q,  off_hi_d;
  logic [7:0]          off_lo_q,  off_lo_d;
  logic [15:0]         gain_hi_q, gain_hi_d;
  logic [7:0]          gain_lo_q, gain_lo_d;
  act_aphase_s         ap_q,      ap_d;
  logic [31:0]         rdata_q,   rdata_d;
  logic                rdy_q;
  logic                resp_q;
  logic [3:0]          hp_q,      hp_d;
  act_sample_s         res_q,     res_d;
  // Reset image of the setup word; a literal cannot be sliced directly
  localparam logic [15:0] setup_rst = `ACT_RST_SETUP;

  // ----------------------------------------------------------------
  // Address phase decode
  // ----------------------------------------------------------------
  wire                 take_ap;
  wire                 hi_zero;
  wire [`ACT_IDX_W-1:0] ap_idx;
  wire                 wr_now;
  wire                 wr_setup;
  wire                 wr_off_hi;
  wire                 wr_off_lo;
  wire                 wr_gain_hi;
  wire                 wr_gain_lo;

  assign take_ap   = hsel & hready & htrans[1];
  assign hi_zero   = ~|haddr[31:`ACT_IDX_W+2];
  assign ap_idx    = haddr[`ACT_IDX_W+1:2];
  // Unaligned or oversize addresses alias nothing: they fall to no register
  assign ap_d.valid = take_ap & hi_zero & (haddr[1:0] == 2'h0);
  assign ap_d.write = hwrite;
  assign ap_d.idx   = ap_idx;

  // Data phase of a write that was taken on the previous edge
  assign wr_now     = ap_q.valid & ap_q.write;
  assign wr_setup   = wr_now & (ap_q.idx == `ACT_IDX_SETUP);
  assign wr_off_hi  = wr_now & (ap_q.idx == `ACT_IDX_OFF_HI);
  assign wr_off_lo  = wr_now & (ap_q.idx == `ACT_IDX_OFF_LO);
  assign wr_gain_hi = wr_now & (ap_q.idx == `ACT_IDX_GAIN_HI);
  assign wr_gain_lo = wr_now & (ap_q.idx == `ACT_IDX_GAIN_LO);

  // ----------------------------------------------------------------
  // Next register values
  // ----------------------------------------------------------------
  assign phase_d   = wr_setup ?
                     hwdata[`ACT_PHASE_HI:`ACT_PHASE_LO] : phase_q; // R1
  assign byp_d     = wr_setup ? hwdata[`ACT_BYP_BIT] : byp_q; // R2
  assign sel_d     = wr_setup ?
                     hwdata[`ACT_SEL_HI:`ACT_SEL_LO] : sel_q; // R3
  assign off_hi_d  = wr_off_hi ? hwdata[15:0] : off_hi_q; // R4
  assign off_lo_d  = wr_off_lo ?
                     hwdata[`ACT_LOWB_HI:`ACT_LOWB_LO] : off_lo_q; // R5
  assign gain_hi_d = wr_gain_hi ? hwdata[15:0] : gain_hi_q; // R6
  assign gain_lo_d = wr_gain_lo ?
                     hwdata[`ACT_LOWB_HI:`ACT_LOWB_LO] : gain_lo_q; // R7

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // The read mux looks at next values, so a read right behind a write
  // to the same register already returns the new contents.
  wire [15:0] rd_setup;
  wire [15:0] rd_off_lo;
  wire [15:0] rd_gain_lo;
  wire [15:0] rd_word;
  wire        rd_take;

  assign rd_setup   = {phase_d, 3'h0, byp_d, sel_d}; // R9
  assign rd_off_lo  = {off_lo_d, 8'h00}; // R9
  assign rd_gain_lo = {gain_lo_d, 8'h00}; // R9
  assign rd_word    =
    (ap_idx == `ACT_IDX_SETUP)   ? rd_setup   :
    (ap_idx == `ACT_IDX_OFF_HI)  ? off_hi_d   :
    (ap_idx == `ACT_IDX_OFF_LO)  ? rd_off_lo  :
    (ap_idx == `ACT_IDX_GAIN_HI) ? gain_hi_d  :
    (ap_idx == `ACT_IDX_GAIN_LO) ? rd_gain_lo : 16'h0000;
  assign rd_take    = ap_d.valid & ~hwrite;
  // Unmapped reads return zero; upper half of the word is always zero
  assign rdata_d    = rd_take ? {16'h0000, rd_word} : 32'h0000_0000;

  // ----------------------------------------------------------------
  // Trim datapath
  // ----------------------------------------------------------------
  // Offset is added first, then the sum is scaled by gain / 2^23. The
  // product is kept at full width so that saturation, not wrap, limits
  // a gain near 2.0 applied to a large sample.
  wire [23:0]          off_full;
  wire [23:0]          gain_full;
  wire signed [24:0]   sum;
  wire signed [25:0]   gain_s;
  wire signed [50:0]   prod;
  wire                 fits;
  wire signed [23:0]   scaled;

  assign off_full  = {off_hi_q, off_lo_q}; // R10
  assign gain_full = {gain_hi_q, gain_lo_q}; // R10
  assign sum       = 25'(sample_in.data) + 25'($signed(off_full));
  assign gain_s    = $signed({2'b00, gain_full}); // R8
  assign prod      = 51'(sum) * 51'(gain_s);
  assign fits      = (prod[50:`ACT_GAIN_FRAC+23] == {5{prod[46]}});
  assign scaled    = fits ? prod[46:`ACT_GAIN_FRAC] :
                     (prod[50] ? 24'sh80_0000 : 24'sh7f_ffff); // R8
  assign res_d.valid = sample_in.valid;
  assign res_d.data  = sample_in.valid ? scaled : res_q.data; // R10

  // Bypass forces the filter off here, else the shared setting passes
  assign hp_d = byp_q ? `ACT_HP_OFF : shared_highpass_setting; // R2

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_q   <= setup_rst[`ACT_PHASE_HI:`ACT_PHASE_LO];
      byp_q     <= setup_rst[`ACT_BYP_BIT];
      sel_q     <= setup_rst[`ACT_SEL_HI:`ACT_SEL_LO];
      off_hi_q  <= `ACT_RST_OFF_HI;
      off_lo_q  <= `ACT_RST_OFF_LO;
      gain_hi_q <= `ACT_RST_GAIN_HI;
      gain_lo_q <= `ACT_RST_GAIN_LO;
    end else begin
      phase_q   <= phase_d;
      byp_q     <= byp_d;
      sel_q     <= sel_d;
      off_hi_q  <= off_hi_d;
      off_lo_q  <= off_lo_d;
      gain_hi_q <= gain_hi_d;
      gain_lo_q <= gain_lo_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_q    <= '0;
      rdata_q <= 32'h0000_0000;
      rdy_q   <= 1'b0;
      resp_q  <= 1'b0;
    end else begin
      ap_q    <= ap_d;
      rdata_q <= rdata_d;
      rdy_q   <= 1'b1;
      resp_q  <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hp_q  <= `ACT_HP_OFF;
      res_q <= '0;
    end else begin
      hp_q  <= hp_d;
      res_q <= res_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hrdata           = rdata_q;
  // Zero wait states; low only while reset holds the bus off
  assign hreadyout        = rdy_q;
  assign hresp            = resp_q;
  assign phase_delay_trim = phase_q; // R1
  assign highpass_bypass  = byp_q; // R2
  assign input_selector   = act_sel_e'(sel_q); // R3
  assign highpass_setting = hp_q;
  assign offset_trim      = {off_hi_q, off_lo_q}; // R10
  assign gain_trim        = {gain_hi_q, gain_lo_q}; // R10
  assign sample_out       = res_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_phase_write: assert property ( // R1
    @(posedge hclk) disable iff (!hresetn)
    wr_setup |=> phase_delay_trim == $past(hwdata[15:6]))
    else $error("phase trim did not take the written value");

  a_bypass_forces_off: assert property ( // R2
    @(posedge hclk) disable iff (!hresetn)
    highpass_bypass |=> highpass_setting == 4'h0)
    else $error("bypassed channel still sees a filter setting");

  a_shared_follows: assert property ( // R2
    @(posedge hclk) disable iff (!hresetn)
    hresetn && !highpass_bypass |=>
      highpass_setting == $past(shared_highpass_setting))
    else $error("channel does not follow the shared setting");

  a_selector_write: assert property ( // R3
    @(posedge hclk) disable iff (!hresetn)
    wr_setup |=> input_selector == act_sel_e'($past(hwdata[1:0])))
    else $error("input selector did not take the written value");

  a_offset_upper: assert property ( // R4
    @(posedge hclk) disable iff (!hresetn)
    wr_off_hi |=> offset_trim[23:8] == $past(hwdata[15:0]))
    else $error("upper offset bits not updated");

  a_offset_lower: assert property ( // R5
    @(posedge hclk) disable iff (!hresetn)
    wr_off_lo |=> offset_trim[7:0] == $past(hwdata[15:8])
      && $stable(offset_trim[23:8]))
    else $error("lower offset byte not updated");

  a_gain_upper: assert property ( // R6
    @(posedge hclk) disable iff (!hresetn)
    wr_gain_hi |=> gain_trim[23:8] == $past(hwdata[15:0]))
    else $error("upper gain bits not updated");

  a_gain_lower: assert property ( // R7
    @(posedge hclk) disable iff (!hresetn)
    wr_gain_lo |=> gain_trim[7:0] == $past(hwdata[15:8])
      && $stable(gain_trim[23:8]))
    else $error("lower gain byte not updated");

  a_unity_gain_path: assert property ( // R8
    @(posedge hclk) disable iff (!hresetn)
    sample_in.valid && gain_trim == 24'h80_0000 && offset_trim == 24'h0
      |=> sample_out.valid && sample_out.data == $past(sample_in.data))
    else $error("unity gain and zero offset changed the sample");

  a_reserved_reads: assert property ( // R9
    @(posedge hclk) disable iff (!hresetn)
    rd_take && (ap_idx == `ACT_IDX_OFF_LO || ap_idx == `ACT_IDX_GAIN_LO)
      |=> hrdata[7:0] == 8'h00 && hrdata[31:16] == 16'h0000)
    else $error("reserved bits of a lower trim read non-zero");

  a_setup_reserved: assert property ( // R9
    @(posedge hclk) disable iff (!hresetn)
    rd_take && ap_idx == `ACT_IDX_SETUP |=> hrdata[5:3] == 3'h0)
    else $error("reserved setup bits read non-zero");

  a_result_timing: assert property ( // R10
    @(posedge hclk) disable iff (!hresetn)
    sample_in.valid |=> sample_out.valid ##0 !$past(sample_in.valid,2)
      || sample_out.valid)
    else $error("result did not follow its sample by one cycle");

  a_bypass_write: assert property ( // R2
    @(posedge hclk) disable iff (!hresetn)
    wr_setup |=> highpass_bypass == $past(hwdata[`ACT_BYP_BIT]))
    else $error("bypass bit did not take the written value");

  a_setup_kept: assert property ( // R1
    @(posedge hclk) disable iff (!hresetn)
    !wr_setup |=> $stable(phase_delay_trim) && $stable(input_selector)
      && $stable(highpass_bypass))
    else $error("setup fields changed without a setup write");

  a_trims_kept: assert property ( // R10
    @(posedge hclk) disable iff (!hresetn)
    !wr_off_hi && !wr_off_lo && !wr_gain_hi && !wr_gain_lo
      |=> $stable(offset_trim) && $stable(gain_trim))
    else $error("trim value changed without a trim write");

  a_read_setup: assert property ( // R1
    @(posedge hclk) disable iff (!hresetn)
    rd_take && ap_idx == `ACT_IDX_SETUP
      |=> hrdata[15:6] == phase_delay_trim && hrdata[2] == highpass_bypass
      && hrdata[1:0] == input_selector)
    else $error("setup read does not match the setup fields");

  a_read_off_upper: assert property ( // R4
    @(posedge hclk) disable iff (!hresetn)
    rd_take && ap_idx == `ACT_IDX_OFF_HI
      |=> hrdata[15:0] == offset_trim[23:8])
    else $error("upper offset read does not match the trim");

  a_read_off_lower: assert property ( // R5
    @(posedge hclk) disable iff (!hresetn)
    rd_take && ap_idx == `ACT_IDX_OFF_LO
      |=> hrdata[`ACT_LOWB_HI:`ACT_LOWB_LO] == offset_trim[7:0])
    else $error("lower offset read does not match the trim");

  a_read_gain_upper: assert property ( // R6
    @(posedge hclk) disable iff (!hresetn)
    rd_take && ap_idx == `ACT_IDX_GAIN_HI
      |=> hrdata[15:0] == gain_trim[23:8])
    else $error("upper gain read does not match the trim");

  a_read_gain_lower: assert property ( // R7
    @(posedge hclk) disable iff (!hresetn)
    rd_take && ap_idx == `ACT_IDX_GAIN_LO
      |=> hrdata[`ACT_LOWB_HI:`ACT_LOWB_LO] == gain_trim[7:0])
    else $error("lower gain read does not match the trim");

  a_read_upper_half: assert property ( // R9
    @(posedge hclk) disable iff (!hresetn)
    rd_take |=> hrdata[31:16] == 16'h0000)
    else $error("upper half of read data is not zero");

  a_read_idle_zero: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !rd_take |=> hrdata == 32'h0000_0000)
    else $error("read data not cleared outside a read");

  a_result_quiet: assert property ( // R10
    @(posedge hclk) disable iff (!hresetn)
    !sample_in.valid |=> !sample_out.valid && $stable(sample_out.data))
    else $error("result appeared or moved without a sample");

  a_bus_okay: assert property (
    @(posedge hclk) disable iff (!hresetn)
    hresetn |=> hreadyout && !hresp)
    else $error("slave stalled or answered with an error");

endmodule : act_channel_trim

// ===== act_channel_trim_tb.sv
/*
  Self-checking bench for the channel trim register bank: AHB-Lite
  register traffic, output fields and the trim stage on samples.
  Assumes act_pkg and act_defs.svh are compiled ahead of this file.
*/
`timescale 1ns/10ps
`include "act_defs.svh"
module act_channel_trim_tb;
  import act_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic              hclk = 1'b0;
  logic              hresetn = 1'b0;
  logic              hsel = 1'b0;
  logic              hwrite = 1'b0;
  logic [1:0]        htrans = 2'h0;
  logic [31:0]       haddr = 32'h0;
  logic [31:0]       hwdata = 32'h0;
  logic [3:0]        hp_shared = 4'h0;
  act_sample_s       sin = '0;
  logic [31:0]       hrdata;
  logic              hreadyout;
  logic              hresp;
  logic [9:0]        phase;
  logic              byp;
  act_sel_e          sel;
  logic [3:0]        hp;
  logic [23:0]       off;
  logic [23:0]       gain;
  act_sample_s       sout;
  logic              rd_phase = 1'b0;
  logic [31:0]       rq[$];
  logic [31:0]       sq[$];
  logic [31:0]       v, o, g, d;
  int                n_errors = 0;
  int                comparisons = 0;
  int                cyc = 0;
  int                seed = 83;

  act_channel_trim DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .shared_highpass_setting(hp_shared),
    .phase_delay_trim(phase), .highpass_bypass(byp),
    .input_selector(sel), .highpass_setting(hp), .offset_trim(off),
    .gain_trim(gain), .sample_in(sin), .sample_out(sout)
  );

  always #5 hclk = ~hclk;

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, got, exp);
    end
  endtask : check

  task stop_test;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  // Reference trim: offset first, then gain, floor shift, saturate
  function logic [31:0] trim(input logic [23:0] x, input logic [23:0] ot,
                             input logic [23:0] gt);
    longint p;
    p = (longint'($signed(x)) + longint'($signed(ot))) *
        longint'({40'h0, gt});
    p = p >>> 23;
    if (p > 64'sh7fffff)
      p = 64'sh7fffff;
    else if (p < -64'sh800000)
      p = -64'sh800000;
    return {{8{p[23]}}, p[23:0]};
  endfunction : trim

  function logic [31:0] ad(input logic [7:0] i);
    return {22'h0, i, 2'b00};
  endfunction : ad

  // Monitor: results are matched against the oldest note
  always @(posedge hclk) begin
    cyc++;
    if (cyc >= 5000) begin
      n_errors++;
      stop_test();
    end else begin
      if (rd_phase && hreadyout === 1'b1) begin
        check(32'(hresp), 32'h0);
        check(hrdata, rq.pop_front());
      end
      if (sout.valid === 1'b1) begin
        if (sq.size() == 0)
          check(32'h1, 32'h0);
        else
          check(32'(sout.data), sq.pop_front());
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus master
  // ----------------------------------------------------------------
  task bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
           input logic [31:0] e);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= a;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    if (!w) begin
      rq.push_back(e);
      rd_phase <= 1'b1;
    end
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_phase <= 1'b0;
  endtask : bus

  task wr(input logic [31:0] a, input logic [31:0] wd);
    bus(1'b1, a, wd, 32'h0);
  endtask : wr

  task rd(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, $random(seed), e);
  endtask : rd

  task do_reset;
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (5) @(posedge hclk);
    // The bus must be held off while reset is applied
    check(32'(hreadyout), 32'h0);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask : do_reset

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    do_reset();
    rd(ad(`ACT_IDX_SETUP), 32'h0);
    rd(ad(`ACT_IDX_OFF_HI), 32'h0);
    rd(ad(`ACT_IDX_OFF_LO), 32'h0);
    rd(ad(`ACT_IDX_GAIN_HI), 32'h8000);
    rd(ad(`ACT_IDX_GAIN_LO), 32'h0);
    #1 check(32'(gain), 32'h800000);
    // All ones: reserved bits stay clear, bypass forces the filter off
    @(posedge hclk);
    hp_shared <= 4'ha;
    wr(ad(`ACT_IDX_SETUP), 32'hffffffff);
    rd(ad(`ACT_IDX_SETUP), 32'hffc7);
    #1 check(32'(phase), 32'h3ff);
    check(32'(byp), 32'h1);
    check(32'(hp), 32'h0);
    // Every selector code, bypass clear so the shared setting shows
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      wr(ad(`ACT_IDX_SETUP), {v[31:3], 1'b0, i[1:0]});
      hp_shared <= v[19:16];
      rd(ad(`ACT_IDX_SETUP), {16'h0, v[15:6], 4'h0, i[1:0]});
      #1 check(32'(sel), 32'(i));
      check(32'(phase), 32'(v[15:6]));
      check(32'(hp), 32'(hp_shared));
    end
    // Trim halves, then back-to-back samples; last pass saturates
    for (int i = 0; i < 3; i++) begin
      o = $random(seed);
      g = $random(seed);
      if (i == 2) begin
        o = 32'hff007fff;
        g = 32'hff00ffff;
      end
      wr(ad(`ACT_IDX_OFF_HI), o);
      wr(ad(`ACT_IDX_OFF_LO), {o[15:0], o[31:16]});
      wr(ad(`ACT_IDX_GAIN_HI), g);
      wr(ad(`ACT_IDX_GAIN_LO), {g[15:0], g[31:16]});
      rd(ad(`ACT_IDX_OFF_LO), {16'h0, o[31:24], 8'h00});
      rd(ad(`ACT_IDX_GAIN_HI), {16'h0, g[15:0]});
      #1 check(32'(off), {8'h0, o[15:0], o[31:24]});
      check(32'(gain), {8'h0, g[15:0], g[31:24]});
      @(posedge hclk);
      for (int k = 0; k < 3; k++) begin
        d = $random(seed);
        sq.push_back(trim(d[23:0], {o[15:0], o[31:24]},
                          {g[15:0], g[31:24]}));
        sin <= {1'b1, d[23:0]};
        @(posedge hclk);
      end
      sin.valid <= 1'b0;
    end
    // Unmapped places read zero and swallow writes
    wr(32'h00000438, 32'h0);
    wr(ad(8'h13), 32'h0);
    rd(ad(8'h13), 32'h0);
    #1 check(32'(sel), 32'h3);
    // Reset in mid-run restores defaults
    do_reset();
    rd(ad(`ACT_IDX_GAIN_HI), 32'h8000);
    #1 check(32'(sel), 32'h0);
    // Defaults give unity gain and no offset: the sample passes as is
    @(posedge hclk);
    d = $random(seed);
    sq.push_back({{8{d[23]}}, d[23:0]});
    sin <= {1'b1, d[23:0]};
    @(posedge hclk);
    sin.valid <= 1'b0;
    repeat (3) @(posedge hclk);
    check(32'(sq.size()), 32'h0);
    check(32'(rq.size()), 32'h0);
    stop_test();
  end
endmodule : act_channel_trim_tb
